// *** hdl/itf_decoder.v ***
// Decoder of six multi-function input terminals into drive commands.
// Assumes terminals arrive asynchronously from switches and that all
// frequency values are in one common unit.
//
// Operation
// - Six terminals, each with function code 0-32.
// - Codes 1-8 give run, direction, stop, jog.
// - Codes 9, 10 start timers; expiry pulses outputs.
// - Code 11 forces main frequency while active.
// - Codes 12-14: overheat, external fault, fault reset.
// - Code 25 enables PID only while running.
// - Codes 19,20,21,26 pick sixteen speed segments.
// - Code 31 counts pulses up to 250 Hz.
// - Code 32 clears the count to zero.
// - Codes 27, 28 step frequency, repeat when held.
// - Three-wire: open buttons edge, opening stop halts.
// - Three-wire forward edge starts, reverse edge reverses.
// - Run closes start; toggle closed means reverse.
// - Terminal run commands need command source one.
// - Two select bits choose acceleration time set.
// - Time select only in speed modes 0,2,3.
// - High over medium over low, else main.
// - High/medium/low selection only in speed mode 2 while running.
// - UP with DOWN keeps frequency unchanged.
// - UP/DOWN only with keyboard source while running.
// - UP stops at maximum, DOWN at minimum.
// - Counter saturates at maximum until reset.
`timescale 1ns/1ns
`default_nettype none
`include "itf_regs.vh"
module itf_decoder #(
  parameter FW = 16,
  parameter TMR_W = 32,
  parameter [TMR_W-1:0] TIMER1_CYCLES = 32'd250000000,
  parameter [TMR_W-1:0] TIMER2_CYCLES = 32'd250000000,
  parameter [31:0] FAST_HOLD_CYCLES = `ITF_FAST_HOLD_MS * `ITF_CLK_MHZ * 1000,
  parameter [31:0] FAST_STEP_CYCLES = `ITF_FAST_STEP_MS * `ITF_CLK_MHZ * 1000,
  parameter [31:0] SLOW_STEP_CYCLES = `ITF_SLOW_STEP_MS * `ITF_CLK_MHZ * 1000,
  parameter [31:0] CNT_GAP_CYCLES = (`ITF_CLK_MHZ * 1000000) / `ITF_CNT_MAX_HZ
) (
  // Clock, reset and enable.
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  // Terminals.
  input wire i_input_terminal_a,
  input wire i_input_terminal_b,
  input wire i_input_terminal_c,
  input wire i_input_terminal_d,
  input wire i_input_terminal_e,
  input wire i_input_terminal_f,
  // Configuration.
  input wire [5:0] i_term_a_function_select,
  input wire [5:0] i_term_b_function_select,
  input wire [5:0] i_term_c_function_select,
  input wire [5:0] i_term_d_function_select,
  input wire [5:0] i_term_e_function_select,
  input wire [5:0] i_term_f_function_select,
  input wire [1:0] i_command_source_select,
  input wire [1:0] i_frequency_source_select,
  input wire [1:0] i_speed_mode_select,
  input wire [FW-1:0] i_main_frequency_setting,
  input wire [FW-1:0] i_low_speed_preset,
  input wire [FW-1:0] i_medium_speed_preset,
  input wire [FW-1:0] i_high_speed_preset,
  input wire [FW-1:0] i_max_frequency,
  input wire [FW-1:0] i_min_frequency,
  input wire i_fault_present,
  // Status.
  output reg o_run_q,
  output reg o_reverse_q,
  output reg o_jog_q,
  output reg o_jog_reverse_q,
  output reg o_force_main_q,
  output reg o_overheat_q,
  output reg o_external_fault_q,
  output reg o_fault_reset_q,
  output reg o_timer1_done_q,
  output reg o_timer2_done_q,
  output reg o_pid_enable_q,
  output reg [3:0] o_segment_q,
  output reg [1:0] o_accel_set_q,
  output reg o_accel_valid_q,
  output reg [FW-1:0] o_frequency_q,
  output reg [15:0] o_pulse_count_q,
  output reg o_zero_count_display_q,
  output reg o_draft_enable_q
);

  // ==========================================================
  // Synchronisers and edge detection.
  wire [5:0] pins = {i_input_terminal_f, i_input_terminal_e, i_input_terminal_d,
                     i_input_terminal_c, i_input_terminal_b, i_input_terminal_a};
  wire [35:0] fsel = {i_term_f_function_select, i_term_e_function_select, i_term_d_function_select,
                      i_term_c_function_select, i_term_b_function_select, i_term_a_function_select};
  reg [5:0] s1_q;
  reg [5:0] s2_q;
  reg [5:0] s3_q;
  reg [5:0] lvl_q;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      lvl_q <= 6'h00;
    end else if (i_ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  reg [5:0] prev_q;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_q <= 6'h00;
    end else if (i_ce) begin
      prev_q <= lvl_q;
    end
  end
  wire [5:0] rise = lvl_q & ~prev_q;
  wire [5:0] fall = ~lvl_q & prev_q;

  // Level, rise and fall of any terminal holding a given code; other codes are ignored.
  function [2:0] itf_sense;
    input [35:0] sel;
    input [5:0] lv;
    input [5:0] ri;
    input [5:0] fa;
    input [5:0] code;
    integer k;
    begin
      itf_sense = 3'h0;
      for (k = 0; k < 6; k = k + 1) begin
        if (sel[k*6 +: 6] == code && code <= `ITF_FN_MAX) begin
          itf_sense = itf_sense | {fa[k], ri[k], lv[k]};
        end
      end
    end
  endfunction

  wire [2:0] f_run = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_RUN);
  wire [2:0] f_fwd = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_FWD);
  wire [2:0] f_rev = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_REV);
  wire [2:0] f_stop = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_STOP);
  wire [2:0] f_dir = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_DIR);
  wire [2:0] f_jog = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_JOG);
  wire [2:0] f_jogf = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_JOGF);
  wire [2:0] f_jogr = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_JOGR);
  wire [2:0] f_t1 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_TMR1);
  wire [2:0] f_t2 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_TMR2);
  wire [2:0] f_force = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_FORCE);
  wire [2:0] f_heat = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_HEAT);
  wire [2:0] f_eflt = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_EFLT);
  wire [2:0] f_frst = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_FRST);
  wire [2:0] f_acc1 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_ACC1);
  wire [2:0] f_acc2 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_ACC2);
  wire [2:0] f_ms1 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_MS1);
  wire [2:0] f_ms2 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_MS2);
  wire [2:0] f_ms3 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_MS3);
  wire [2:0] f_ms4 = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_MS4);
  wire [2:0] f_high = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_HIGH);
  wire [2:0] f_med = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_MED);
  wire [2:0] f_low = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_LOW);
  wire [2:0] f_pid = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_PID);
  wire [2:0] f_up = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_UP);
  wire [2:0] f_down = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_DOWN);
  wire [2:0] f_draft = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_DRAFT);
  wire [2:0] f_cnt = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_CNT);
  wire [2:0] f_crst = itf_sense(fsel, lvl_q, rise, fall, `ITF_FN_CRST);

  // ==========================================================
  // Run and direction commands.
  wire term_ctl = (i_command_source_select == `ITF_CMD_TERMINAL);
  wire stop_cfg = |itf_sense(fsel, 6'h3F, 6'h00, 6'h00, `ITF_FN_STOP);
  wire run_cfg = |itf_sense(fsel, 6'h3F, 6'h00, 6'h00, `ITF_FN_RUN);
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_run_q <= 1'b0;
      o_reverse_q <= 1'b0;
      o_jog_q <= 1'b0;
      o_jog_reverse_q <= 1'b0;
    end else if (i_ce) begin
      if (!term_ctl) begin
        o_run_q <= 1'b0;
        o_jog_q <= 1'b0;
      end else if (f_stop[2] || (f_stop[0] == 1'b0 && stop_cfg && o_run_q)) begin
        o_run_q <= 1'b0;
      end else if (run_cfg) begin
        o_run_q <= f_run[0];
        o_reverse_q <= f_dir[0];
      end else if (f_fwd[1]) begin
        o_run_q <= 1'b1;
        o_reverse_q <= 1'b0;
      end else if (f_rev[1]) begin
        o_run_q <= 1'b1;
        o_reverse_q <= 1'b1;
      end else if (!stop_cfg && (f_fwd[2] || f_rev[2]) && !f_fwd[0] && !f_rev[0]) begin
        o_run_q <= 1'b0;
      end
      if (term_ctl && !o_run_q) begin
        o_jog_q <= f_jog[0] | f_jogf[0] | f_jogr[0];
        o_jog_reverse_q <= f_jogr[0];
      end else begin
        o_jog_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // External timers.
  reg [TMR_W-1:0] t1_q;
  reg [TMR_W-1:0] t2_q;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      t1_q <= {TMR_W{1'b0}};
      t2_q <= {TMR_W{1'b0}};
      o_timer1_done_q <= 1'b0;
      o_timer2_done_q <= 1'b0;
    end else if (i_ce) begin
      o_timer1_done_q <= (t1_q == {{(TMR_W-1){1'b0}}, 1'b1});
      o_timer2_done_q <= (t2_q == {{(TMR_W-1){1'b0}}, 1'b1});
      if (f_t1[1]) begin
        t1_q <= TIMER1_CYCLES;
      end else if (t1_q != {TMR_W{1'b0}}) begin
        t1_q <= t1_q - 1'b1;
      end
      if (f_t2[1]) begin
        t2_q <= TIMER2_CYCLES;
      end else if (t2_q != {TMR_W{1'b0}}) begin
        t2_q <= t2_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // Level functions and fault reset edge: force, faults, PID, speed and time selection.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_force_main_q <= 1'b0;
      o_overheat_q <= 1'b0;
      o_external_fault_q <= 1'b0;
      o_fault_reset_q <= 1'b0;
      o_pid_enable_q <= 1'b0;
      o_segment_q <= 4'h0;
      o_accel_set_q <= 2'h0;
      o_accel_valid_q <= 1'b0;
      o_draft_enable_q <= 1'b0;
    end else if (i_ce) begin
      o_force_main_q <= f_force[0];
      o_overheat_q <= f_heat[0];
      o_external_fault_q <= f_eflt[0];
      o_fault_reset_q <= f_frst[1] & ~i_fault_present;
      o_pid_enable_q <= f_pid[0] & o_run_q;
      o_segment_q <= {f_ms4[0], f_ms3[0], f_ms2[0], f_ms1[0]};
      o_draft_enable_q <= f_draft[0];
      if (i_speed_mode_select != `ITF_SPD_INTMS) begin
        o_accel_set_q <= {f_acc2[0], f_acc1[0]};
        o_accel_valid_q <= 1'b1;
      end else begin
        o_accel_set_q <= 2'h0;
        o_accel_valid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Frequency selection and UP/DOWN trimming.
  reg [FW-1:0] trim_q;
  reg [31:0] hold_q;
  reg [31:0] rep_q;
  wire ud_ok = (i_frequency_source_select == `ITF_FSRC_KEYBOARD) && o_run_q;
  wire up_only = f_up[0] & ~f_down[0];
  wire dn_only = f_down[0] & ~f_up[0];
  wire held = up_only | dn_only;
  wire step_now = ((f_up[1] | f_down[1]) && held) ||
                  (held && rep_q == 32'd0 && hold_q != 32'd0);
  wire [31:0] period = (hold_q >= FAST_HOLD_CYCLES) ? SLOW_STEP_CYCLES : FAST_STEP_CYCLES;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      trim_q <= {FW{1'b0}};
      hold_q <= 32'd0;
      rep_q <= 32'd0;
    end else if (i_ce) begin
      if (!ud_ok || !held) begin
        hold_q <= 32'd0;
        rep_q <= 32'd0;
        if (!ud_ok) begin
          trim_q <= o_frequency_q;
        end
      end else begin
        if (hold_q != 32'hFFFFFFFF) begin
          hold_q <= hold_q + 32'd1;
        end
        rep_q <= step_now ? period - 32'd1 : rep_q - 32'd1;
        if (step_now && up_only && trim_q < i_max_frequency) begin
          trim_q <= trim_q + 1'b1;
        end else if (step_now && dn_only && trim_q > i_min_frequency) begin
          trim_q <= trim_q - 1'b1;
        end
      end
    end
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_frequency_q <= {FW{1'b0}};
    end else if (i_ce) begin
      if (f_force[0]) begin
        o_frequency_q <= i_main_frequency_setting;
      end else if (i_speed_mode_select == `ITF_SPD_EXT4 && o_run_q) begin
        if (f_high[0]) begin
          o_frequency_q <= i_high_speed_preset;
        end else if (f_med[0]) begin
          o_frequency_q <= i_medium_speed_preset;
        end else if (f_low[0]) begin
          o_frequency_q <= i_low_speed_preset;
        end else begin
          o_frequency_q <= i_main_frequency_setting;
        end
      end else if (ud_ok) begin
        o_frequency_q <= trim_q;
      end else begin
        o_frequency_q <= i_main_frequency_setting;
      end
    end
  end

  // ==========================================================
  // Pulse counter.
  reg [31:0] gap_q;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pulse_count_q <= 16'h0000;
      o_zero_count_display_q <= 1'b1;
      gap_q <= 32'd0;
    end else if (i_ce) begin
      if (gap_q != 32'd0) begin
        gap_q <= gap_q - 32'd1;
      end
      if (f_crst[1]) begin
        o_pulse_count_q <= 16'h0000;
        o_zero_count_display_q <= 1'b1;
      end else if (f_cnt[1] && gap_q == 32'd0) begin
        gap_q <= CNT_GAP_CYCLES - 32'd1;
        if (o_pulse_count_q != `ITF_CNT_MAX) begin
          o_pulse_count_q <= o_pulse_count_q + 16'h0001;
          o_zero_count_display_q <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** hdl/itf_regs.vh ***
// Constants for the input terminal function decoder.
// Assumes inclusion by the decoder module and the self-checking bench.
`ifndef ITF_REGS_VH
`define ITF_REGS_VH
// ==========================================================
// Function codes
`define ITF_FN_RUN 6'h01
`define ITF_FN_FWD 6'h02
`define ITF_FN_REV 6'h03
`define ITF_FN_STOP 6'h04
`define ITF_FN_DIR 6'h05
`define ITF_FN_JOG 6'h06
`define ITF_FN_JOGF 6'h07
`define ITF_FN_JOGR 6'h08
`define ITF_FN_TMR1 6'h09
`define ITF_FN_TMR2 6'h0A
`define ITF_FN_FORCE 6'h0B
`define ITF_FN_HEAT 6'h0C
`define ITF_FN_EFLT 6'h0D
`define ITF_FN_FRST 6'h0E
`define ITF_FN_ACC1 6'h11
`define ITF_FN_ACC2 6'h12
`define ITF_FN_MS1 6'h13
`define ITF_FN_MS2 6'h14
`define ITF_FN_MS3 6'h15
`define ITF_FN_HIGH 6'h16
`define ITF_FN_MED 6'h17
`define ITF_FN_LOW 6'h18
`define ITF_FN_PID 6'h19
`define ITF_FN_MS4 6'h1A
`define ITF_FN_UP 6'h1B
`define ITF_FN_DOWN 6'h1C
`define ITF_FN_DRAFT 6'h1D
`define ITF_FN_CNT 6'h1F
`define ITF_FN_CRST 6'h20
`define ITF_FN_MAX 6'h20
// ==========================================================
// Reset values of the terminal function selects
`define ITF_RST_A 6'h02
`define ITF_RST_B 6'h03
`define ITF_RST_C 6'h0E
`define ITF_RST_D 6'h16
`define ITF_RST_E 6'h17
`define ITF_RST_F 6'h18
// ==========================================================
// Parameter values and limits
`define ITF_CMD_TERMINAL 2'h1
`define ITF_FSRC_KEYBOARD 2'h0
`define ITF_SPD_EXT4 2'h2
`define ITF_SPD_INTMS 2'h1
`define ITF_CNT_MAX 16'hFFFF
// ==========================================================
// Timing: clock in MHz, counter rate in Hz, UP/DOWN step timing in ms
`define ITF_CLK_MHZ 250
`define ITF_CNT_MAX_HZ 250
`define ITF_FAST_HOLD_MS 500
`define ITF_FAST_STEP_MS 10
`define ITF_SLOW_STEP_MS 50
`endif

// *** verif/itf_switch_model.sv ***
// Switch, button and pulse contact model for the terminal decoder bench.
// Assumes the bench changes the operator actions just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module itf_switch_model (
  // Operator actions.
  input wire logic [5:0] i_press,
  input wire logic [5:0] i_nc_mask,
  // Contact levels at the terminals.
  output logic [5:0] o_term
);
  // ==========================================================
  // Contacts
  // A normally closed button reads closed until it is pressed.
  assign o_term = i_press ^ i_nc_mask;
endmodule
`default_nettype wire

// *** verif/itf_decoder_sva.sv ***
// Concurrent checks on the ports of the terminal decoder.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module itf_decoder_sva (
  // Clock and reset.
  input wire i_clk,
  input wire i_reset,
  // Configuration.
  input wire [1:0] i_command_source_select,
  input wire [1:0] i_speed_mode_select,
  // Status.
  input wire o_run_q,
  input wire o_jog_q,
  input wire o_fault_reset_q,
  input wire o_timer1_done_q,
  input wire o_timer2_done_q,
  input wire o_pid_enable_q,
  input wire o_accel_valid_q,
  input wire [15:0] o_pulse_count_q,
  input wire o_zero_count_display_q
);
  // ==========================================================
  // Sequences
  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_internal_mode;
    (i_speed_mode_select == 2'h1) [*6];
  endsequence
  sequence s_source_off;
    (i_command_source_select != 2'h1) [*6];
  endsequence
  // ==========================================================
  // Assertions
  a_accel_blocked: assert property (s_internal_mode |-> !o_accel_valid_q)
    else $error("accel select valid in internal speed mode");
  a_source_gate: assert property (s_source_off |-> !$rose(o_run_q))
    else $error("run started without terminal command source");
  a_pid_running: assert property (o_pid_enable_q |-> o_run_q || $past(o_run_q))
    else $error("pid enabled while stopped");
  a_jog_stopped: assert property ($rose(o_jog_q) |-> !$past(o_run_q))
    else $error("jog accepted while running");
  a_reset_pulse: assert property (o_fault_reset_q |=> !o_fault_reset_q)
    else $error("fault reset longer than one cycle");
  a_timer_one: assert property (o_timer1_done_q |=> !o_timer1_done_q)
    else $error("timer one expiry longer than one cycle");
  a_timer_two: assert property (o_timer2_done_q |=> !o_timer2_done_q)
    else $error("timer two expiry longer than one cycle");
  a_count_step: assert property (o_pulse_count_q != 16'h0 |=>
    (o_pulse_count_q == 16'h0) || (o_pulse_count_q - $past(o_pulse_count_q) <= 16'h1))
    else $error("count moved by more than one");
  a_count_sat: assert property (o_pulse_count_q == 16'hFFFF |=>
    (o_pulse_count_q == 16'hFFFF) || (o_pulse_count_q == 16'h0))
    else $error("count left saturation");
  a_zero_shown: assert property (o_pulse_count_q != 16'h0 |-> !o_zero_count_display_q)
    else $error("zero display with nonzero count");
endmodule
bind itf_decoder itf_decoder_sva chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_command_source_select(i_command_source_select), .i_speed_mode_select(i_speed_mode_select),
  .o_run_q(o_run_q), .o_jog_q(o_jog_q), .o_fault_reset_q(o_fault_reset_q),
  .o_timer1_done_q(o_timer1_done_q), .o_timer2_done_q(o_timer2_done_q), .o_pid_enable_q(o_pid_enable_q),
  .o_accel_valid_q(o_accel_valid_q), .o_pulse_count_q(o_pulse_count_q),
  .o_zero_count_display_q(o_zero_count_display_q));
`default_nettype wire

// *** verif/input_terminal_function_decoder_tb.sv ***
// Self-checking bench for the terminal decoder with its switch model.
// Assumes the decoder header and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
`include "itf_regs.vh"
module input_terminal_function_decoder_tb;
  // ==========================================================
  // Signals
  logic i_clk, i_reset, fault, ce;
  logic [15:0] maxf, minf;
  localparam logic [31:0] TMR_CYC = 32'd20;
  localparam logic [31:0] HOLD_CYC = 32'd40;
  localparam logic [31:0] FAST_CYC = 32'd4;
  localparam logic [31:0] SLOW_CYC = 32'd8;
  localparam logic [31:0] GAP_CYC = 32'd4;
  logic [5:0] press, nc, f [0:5];
  logic [1:0] csrc, fsrc, smode;
  logic [15:0] mainf, lowp, medp, highp, ec, r;
  wire [5:0] t;
  wire run, reverse_command, jog, jogr, frc, heat, eflt, frst, t1, t2, pid, drft, accv, zd;
  wire [3:0] seg;
  wire [1:0] acc;
  wire [15:0] freq, cnt;
  int n_mismatch, comparisons, i, k;
  int unsigned seed;
  itf_switch_model sw_u (.i_press(press), .i_nc_mask(nc), .o_term(t));
  itf_decoder #(.TIMER1_CYCLES(TMR_CYC), .TIMER2_CYCLES(TMR_CYC), .FAST_HOLD_CYCLES(HOLD_CYC),
    .FAST_STEP_CYCLES(FAST_CYC), .SLOW_STEP_CYCLES(SLOW_CYC), .CNT_GAP_CYCLES(GAP_CYC)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_input_terminal_a(t[0]), .i_input_terminal_b(t[1]),
    .i_input_terminal_c(t[2]), .i_input_terminal_d(t[3]), .i_input_terminal_e(t[4]), .i_input_terminal_f(t[5]),
    .i_term_a_function_select(f[0]), .i_term_b_function_select(f[1]), .i_term_c_function_select(f[2]),
    .i_term_d_function_select(f[3]), .i_term_e_function_select(f[4]), .i_term_f_function_select(f[5]),
    .i_command_source_select(csrc), .i_frequency_source_select(fsrc), .i_speed_mode_select(smode),
    .i_main_frequency_setting(mainf), .i_low_speed_preset(lowp), .i_medium_speed_preset(medp),
    .i_high_speed_preset(highp), .i_max_frequency(maxf), .i_min_frequency(minf), .i_fault_present(fault),
    .o_run_q(run), .o_reverse_q(reverse_command), .o_jog_q(jog), .o_jog_reverse_q(jogr), .o_force_main_q(frc),
    .o_overheat_q(heat), .o_external_fault_q(eflt), .o_fault_reset_q(frst), .o_timer1_done_q(t1),
    .o_timer2_done_q(t2), .o_pid_enable_q(pid), .o_segment_q(seg), .o_accel_set_q(acc), .o_accel_valid_q(accv),
    .o_frequency_q(freq), .o_pulse_count_q(cnt), .o_zero_count_display_q(zd), .o_draft_enable_q(drft));
  // ==========================================================
  // Helpers
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic cb(input logic got, input logic exp, input string w);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %b want %b", $time, w, got, exp);
    end
  endtask
  task automatic cw(input logic [15:0] got, input logic [15:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic cfg(input logic [5:0] a, b, c, d, e, g);
    f[0] = a;
    f[1] = b;
    f[2] = c;
    f[3] = d;
    f[4] = e;
    f[5] = g;
    press = 6'h00;
    cyc(8);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    finish_test();
  end
  // ==========================================================
  // Tests
  initial begin
    seed = 62071;
    n_mismatch = 0;
    comparisons = 0;
    {i_reset, fault, press, nc, csrc, fsrc, smode} = {2'b10, 12'h000, 6'h15};
    ce = 1'b1;
    maxf = 16'hFFFF;
    minf = 16'h0000;
    mainf = rnd();
    lowp = rnd();
    medp = rnd();
    highp = rnd();
    for (i = 0; i < 6; i++) f[i] = 6'h00;
    repeat (2) @(posedge i_clk);
    #1 i_reset = 1'b0;
    cb(zd, 1'b1, "display");
    cfg(`ITF_FN_CNT, `ITF_FN_CRST, 6'h0, 6'h0, 6'h0, 6'h0);
    for (k = 1; k < 4; k++) begin
      press = 6'h01;
      cyc(6);
      press = 6'h00;
      cyc(6);
      cw(cnt, k[15:0], "count");
    end
    cb(zd, 1'b0, "display");
    press = 6'h02;
    cyc(8);
    cw(cnt, 16'h0, "clear");
    cb(zd, 1'b1, "display");
    press = 6'h01;
    cyc(8);
    cw(cnt, 16'h1, "recount");
    $display("Test counter finished");
    cfg(`ITF_FN_RUN, `ITF_FN_DIR, 6'h0, 6'h0, 6'h0, 6'h0);
    press = 6'h01;
    cyc(8);
    cb(run, 1'b1, "run");
    cb(reverse_command, 1'b0, "dir");
    press = 6'h03;
    cyc(8);
    cb(reverse_command, 1'b1, "dir");
    press = 6'h00;
    cyc(8);
    cb(run, 1'b0, "run");
    csrc = 2'h2;
    press = 6'h01;
    cyc(8);
    cb(run, 1'b0, "source");
    csrc = 2'h1;
    nc = 6'h04;
    cfg(`ITF_FN_FWD, `ITF_FN_REV, `ITF_FN_STOP, 6'h0, 6'h0, 6'h0);
    for (k = 1; k < 3; k++) begin
      press = k[5:0];
      cyc(8);
      press = 6'h00;
      cyc(8);
      cb(run, 1'b1, "edge run");
      cb(reverse_command, k == 2, "edge dir");
    end
    press = 6'h04;
    cyc(8);
    cb(run, 1'b0, "stop");
    nc = 6'h00;
    $display("Test wiring finished");
    cfg(6'h0, 6'h0, 6'h0, `ITF_FN_ACC1, `ITF_FN_ACC2, 6'h0);
    for (i = 0; i < 4; i++) begin
      smode = i[1:0];
      for (k = 0; k < 4; k++) begin
        press = {1'b0, k[1:0], 3'b000};
        cyc(8);
        cb(accv, i != 1, "accel valid");
        if (i != 1) cw({14'h0, acc}, k[15:0], "accel");
      end
    end
    smode = 2'h0;
    cfg(`ITF_FN_MS1, `ITF_FN_MS2, `ITF_FN_MS3, `ITF_FN_MS4, 6'h0, 6'h0);
    r = rnd();
    for (k = 0; k < 16; k++) begin
      ec = (k[15:0] ^ r) & 16'h000F;
      press = {2'b00, ec[3:0]};
      cyc(8);
      cw({12'h0, seg}, ec, "segment");
    end
    cfg(`ITF_FN_RUN, 6'h0, `ITF_FN_FORCE, `ITF_FN_HIGH, `ITF_FN_MED, `ITF_FN_LOW);
    smode = 2'h2;
    for (k = 0; k < 8; k++) begin
      press = {k[2:0], 3'b001};
      cyc(8);
      ec = k[0] ? highp : k[1] ? medp : k[2] ? lowp : mainf;
      cw(freq, ec, "speed");
    end
    press = 6'h0D;
    cyc(8);
    cb(frc, 1'b1, "force");
    cw(freq, mainf, "force");
    smode = 2'h0;
    press = 6'h21;
    cyc(8);
    cw(freq, mainf, "mode");
    $display("Test speed finished");
    csrc = 2'h2;
    cfg(`ITF_FN_JOG, `ITF_FN_TMR1, `ITF_FN_TMR2, `ITF_FN_HEAT, `ITF_FN_EFLT, `ITF_FN_PID);
    csrc = 2'h1;
    cyc(1);
    press = 6'h39;
    cyc(8);
    cb(jog, 1'b1, "jog");
    cb(heat, 1'b1, "heat");
    cb(eflt, 1'b1, "fault");
    cb(pid, 1'b0, "pid");
    press = 6'h02;
    for (i = 0; i < 60 && t1 !== 1'b1; i++) cyc(1);
    cb(t1, 1'b1, "timer1");
    press = 6'h04;
    for (i = 0; i < 60 && t2 !== 1'b1; i++) cyc(1);
    cb(t2, 1'b1, "timer2");
    cfg(`ITF_FN_FRST, `ITF_FN_RUN, 6'h0, 6'h0, 6'h0, `ITF_FN_PID);
    press = 6'h01;
    for (i = 0; i < 30 && frst !== 1'b1; i++) cyc(1);
    cb(frst, 1'b1, "fault reset");
    press = 6'h22;
    cyc(8);
    cb(pid, 1'b1, "pid");
    csrc = 2'h2;
    cfg(6'h0F, 6'h10, 6'h1E, 6'h21, 6'h3F, 6'h00);
    csrc = 2'h1;
    cyc(1);
    press = 6'h3F;
    cyc(8);
    cb(run | jog | heat | eflt | pid, 1'b0, "reserved");
    cw({12'h0, seg}, 16'h0, "reserved");
    cw(cnt, 16'h1, "reserved");
    $display("Test misc finished");
    finish_test();
  end
endmodule
`default_nettype wire
